// File: rtl/cawd_defines.svh
`ifndef CAWD_DEFINES_SVH
`define CAWD_DEFINES_SVH

// Register select codes on the special function register port
`define CAWD_SEL_CTL        3'h0
`define CAWD_SEL_MODE       3'h1
`define CAWD_SEL_CNT_LO     3'h2
`define CAWD_SEL_CNT_HI     3'h3
`define CAWD_SEL_M5_MODE    3'h4
`define CAWD_SEL_M5_OFFSET  3'h5
`define CAWD_SEL_M5_COMPARE 3'h6

// Control register fields
`define CAWD_CTL_CF         7
`define CAWD_CTL_CR         6
`define CAWD_CTL_MODULE5_EVENT_FLAG       5

// Counter mode register fields
`define CAWD_MD_IDLE_SUSPEND_BIT        7
`define CAWD_MD_WATCHDOG_ENABLE_BIT        6
`define CAWD_MD_WATCHDOG_LOCK_BIT       5
`define CAWD_MD_CPS_HI      3
`define CAWD_MD_CPS_LO      1
`define CAWD_MD_ECF         0

// Module 5 mode register fields and the forced software timer value
`define CAWD_M5_ECOM        6
`define CAWD_M5_MAT         3
`define CAWD_M5_SWT         8'h48

// Reset values
`define CAWD_RST_BYTE       8'h00
`define CAWD_RST_CPS        3'h0

// Clock source codes and prescale counts
`define CAWD_CPS_DIV12      3'h0
`define CAWD_CPS_DIV4       3'h1
`define CAWD_CPS_TMR        3'h2
`define CAWD_CPS_EXT        3'h3
`define CAWD_CPS_SYS        3'h4
`define CAWD_CPS_DIV8       3'h5
`define CAWD_DIV12_LAST     4'hB
`define CAWD_DIV8_LAST      4'h7
`define CAWD_DIV4_LAST      4'h3

`endif

// File: rtl/cawd_pkg.sv
package cawd_pkg;

    typedef enum logic [1:0] {
        WD_OFF,
        WD_ON,
        WD_LOCKED
    } cawd_wd_state_t;

    typedef struct packed {
        logic [3:0] pre;
        logic       ext_q;
        logic       tick;
    } cawd_div_st_t;

    typedef struct packed {
        cawd_wd_state_t wd;
        logic           cf;
        logic           cr;
        logic [5:0]     ccf;
        logic           idle_suspend_bit;
        logic [2:0]     cps;
        logic           ecf;
        logic [7:0]     lo;
        logic [7:0]     hi;
        logic [7:0]     m5mode;
        logic [7:0]     off;
        logic [7:0]     cmp;
        logic [7:0]     rdata;
        logic           rst_req;
    } cawd_top_st_t;

endpackage : cawd_pkg

// File: rtl/cawd_clkdiv.sv
`timescale 1ns/1ns
`include "cawd_defines.svh"

module cawd_clkdiv
    import cawd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [2:0] cps_i,
    input  wire logic       tmr_ovf_i,
    input  wire logic       ext_clk_i,
    output logic            tick_o
);

    cawd_div_st_t st;
    cawd_div_st_t next_st;
    logic [3:0]   last;

    always_comb begin
        next_st = st;
        last    = `CAWD_DIV12_LAST;
        case (cps_i)
            `CAWD_CPS_DIV4: last = `CAWD_DIV4_LAST;
            `CAWD_CPS_DIV8: last = `CAWD_DIV8_LAST;
            default:        last = `CAWD_DIV12_LAST;
        endcase
        if (ce_i) begin
            next_st.ext_q = ext_clk_i;
            next_st.pre   = (st.pre >= last) ? 4'h0 : st.pre + 4'h1;
            case (cps_i)
                `CAWD_CPS_TMR: next_st.tick = tmr_ovf_i;
                `CAWD_CPS_EXT: next_st.tick = ext_clk_i & ~st.ext_q;
                `CAWD_CPS_SYS: next_st.tick = 1'b1;
                default:       next_st.tick = (st.pre >= last);
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule : cawd_clkdiv

// File: rtl/cawd_top.sv
`timescale 1ns/1ns
`include "cawd_defines.svh"

module cawd_top
    import cawd_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [2:0] sfr_sel_i,
    input  wire logic       sfr_we_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       cpu_idle_i,
    input  wire logic       tmr_ovf_i,
    input  wire logic       ext_clk_i,
    output logic            wd_enabled_o,
    output logic            wd_rst_o
);

    cawd_top_st_t st;
    cawd_top_st_t next_st;
    logic         tick;
    logic         wd_on;
    logic         run;
    logic         step;
    logic         lo_ovf;
    logic         cnt_ovf;
    logic         hi_match;
    logic         m5_match;
    logic         wr_ctl;
    logic         wr_mode;
    logic         fire;
    logic         force_rst;
    logic [7:0]   m5mode_rd;

    cawd_clkdiv u_clkdiv (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .cps_i     (st.cps),
        .tmr_ovf_i (tmr_ovf_i),
        .ext_clk_i (ext_clk_i),
        .tick_o    (tick)
    );

    assign wd_on     = (st.wd != WD_OFF);
    assign run       = st.cr | wd_on;
    assign step      = ce_i & tick & run & ~(st.idle_suspend_bit & cpu_idle_i);
    assign lo_ovf    = step & (st.lo == 8'hFF);
    assign cnt_ovf   = lo_ovf & (st.hi == 8'hFF);
    assign hi_match  = (st.cmp == st.hi);
    assign m5_match  = step & ({st.cmp, st.off} == {st.hi, st.lo});
    assign wr_ctl    = ce_i & sfr_we_i & (sfr_sel_i == `CAWD_SEL_CTL);
    assign wr_mode   = ce_i & sfr_we_i & (sfr_sel_i == `CAWD_SEL_MODE);
    // Match sampled at the overflow step itself, not a cycle later
    assign fire      = wd_on & lo_ovf & hi_match;
    assign force_rst = wd_on & wr_ctl & sfr_wdata_i[`CAWD_CTL_MODULE5_EVENT_FLAG];
    assign m5mode_rd = wd_on ? `CAWD_M5_SWT : st.m5mode;

    always_comb begin
        next_st = st;
        if (ce_i) begin
            next_st.rst_req = 1'b0;
            // Counter advance; counter byte writes below are blocked while watchdog runs
            if (step) begin
                next_st.lo = st.lo + 8'h01;
                if (lo_ovf) begin
                    next_st.hi = st.hi + 8'h01;
                end
            end
            if (sfr_we_i) begin
                case (sfr_sel_i)
                    `CAWD_SEL_CTL: begin
                        next_st.cf  = sfr_wdata_i[`CAWD_CTL_CF];
                        next_st.cr  = sfr_wdata_i[`CAWD_CTL_CR];
                        next_st.ccf = sfr_wdata_i[5:0];
                    end
                    `CAWD_SEL_MODE: begin
                        if (!wd_on) begin
                            next_st.idle_suspend_bit = sfr_wdata_i[`CAWD_MD_IDLE_SUSPEND_BIT];
                            next_st.cps  = sfr_wdata_i[`CAWD_MD_CPS_HI:`CAWD_MD_CPS_LO];
                        end
                        next_st.ecf = sfr_wdata_i[`CAWD_MD_ECF];
                    end
                    `CAWD_SEL_CNT_LO: begin
                        if (!wd_on) begin
                            next_st.lo = sfr_wdata_i;
                        end
                    end
                    `CAWD_SEL_CNT_HI: begin
                        if (!wd_on) begin
                            next_st.hi = sfr_wdata_i;
                        end
                    end
                    `CAWD_SEL_M5_MODE: begin
                        if (!wd_on) begin
                            next_st.m5mode = sfr_wdata_i;
                        end
                    end
                    `CAWD_SEL_M5_OFFSET: begin
                        next_st.off = sfr_wdata_i;
                    end
                    `CAWD_SEL_M5_COMPARE: begin
                        // Service while watchdog on: written data is dropped, timeout restarts; with it off the data is stored
                        next_st.cmp = wd_on ? st.hi + st.off : sfr_wdata_i;
                    end
                    default: begin
                    end
                endcase
            end
            // Enable state machine
            if (wr_mode) begin
                case (st.wd)
                    WD_LOCKED: next_st.wd = WD_LOCKED;
                    default: begin
                        if (sfr_wdata_i[`CAWD_MD_WATCHDOG_LOCK_BIT]) begin
                            next_st.wd = WD_LOCKED;
                        end else if (sfr_wdata_i[`CAWD_MD_WATCHDOG_ENABLE_BIT]) begin
                            next_st.wd = WD_ON;
                        end else begin
                            next_st.wd = WD_OFF;
                        end
                    end
                endcase
            end
            // Hardware sets win over a simultaneous software clear
            if (cnt_ovf) begin
                next_st.cf = 1'b1;
            end
            if (!wd_on && m5_match && st.m5mode[`CAWD_M5_ECOM] && st.m5mode[`CAWD_M5_MAT]) begin
                next_st.ccf[5] = 1'b1;
            end
            // A cause in the cycle while a pulse is high on wd_rst_o is dropped, so each pulse lasts one cycle with ce_i high; ce_i low holds it
            next_st.rst_req = (fire | force_rst) & ~st.rst_req;
            case (sfr_sel_i)
                `CAWD_SEL_CTL: begin
                    next_st.rdata = {st.cf, st.cr, st.ccf};
                end
                `CAWD_SEL_MODE: begin
                    next_st.rdata = {st.idle_suspend_bit, wd_on, st.wd == WD_LOCKED, 1'b0,
                                     st.cps, st.ecf};
                end
                `CAWD_SEL_CNT_LO:      next_st.rdata = st.lo;
                `CAWD_SEL_CNT_HI:      next_st.rdata = st.hi;
                `CAWD_SEL_M5_MODE:     next_st.rdata = m5mode_rd;
                `CAWD_SEL_M5_OFFSET:   next_st.rdata = st.off;
                `CAWD_SEL_M5_COMPARE:  next_st.rdata = st.cmp;
                default:               next_st.rdata = `CAWD_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st         <= '0;
            st.wd      <= WD_ON;
            st.cps     <= `CAWD_RST_CPS;
            st.lo      <= `CAWD_RST_BYTE;
            st.off     <= `CAWD_RST_BYTE;
        end else begin
            st <= next_st;
        end
    end

    assign sfr_rdata_o  = st.rdata;
    assign wd_enabled_o = wd_on;
    assign wd_rst_o     = st.rst_req;

    // Checks
    logic [15:0] cnt;
    assign cnt = {st.hi, st.lo};

    AST_RUN_FORCED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && !st.cr && step && !sfr_we_i |=> cnt == $past(cnt) + 16'h0001)
        else $error("Counter did not advance with watchdog on");

    AST_CNT_WR_BLOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && ce_i && sfr_we_i && sfr_sel_i == `CAWD_SEL_CNT_LO && !step
        |=> st.lo == $past(st.lo))
        else $error("Counter low byte written while watchdog on");

    AST_CFG_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on |=> st.cps == $past(st.cps) && st.idle_suspend_bit == $past(st.idle_suspend_bit))
        else $error("Clock source or idle bit changed while watchdog on");

    AST_M5_SWT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && ce_i && sfr_sel_i == `CAWD_SEL_M5_MODE |=> sfr_rdata_o == `CAWD_M5_SWT)
        else $error("Module 5 not shown in software timer mode");

    AST_CR_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && !st.cr && ce_i && sfr_sel_i == `CAWD_SEL_CTL
        |=> !sfr_rdata_o[`CAWD_CTL_CR])
        else $error("Run bit read as one without software setting it");

    AST_SERVICE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && ce_i && sfr_we_i && sfr_sel_i == `CAWD_SEL_M5_COMPARE
        |=> st.cmp == 8'($past(st.hi) + $past(st.off)))
        else $error("Service write did not load high byte plus offset");

    AST_FIRE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && lo_ovf && st.cmp == st.hi && !st.rst_req |=> wd_rst_o)
        else $error("Missed watchdog reset on overflow match");

    AST_NO_FALSE_FIRE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ce_i && !lo_ovf && !force_rst |=> !wd_rst_o)
        else $error("Watchdog reset without a cause");

    AST_FORCE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        force_rst && !st.rst_req |=> wd_rst_o)
        else $error("Forced watchdog reset missing");

    AST_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        st.wd == WD_LOCKED |=> st.wd == WD_LOCKED)
        else $error("Locked watchdog was disabled");

    AST_PULSE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_rst_o && ce_i |=> !wd_rst_o)
        else $error("Reset request longer than one cycle");

    AST_IDLE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && st.idle_suspend_bit && cpu_idle_i |=> cnt == $past(cnt))
        else $error("Counter advanced in idle with suspend set");

    COV_FIRE:    cover property (@(posedge clk_i) disable iff (!rst_n_i) fire);
    COV_FORCE:   cover property (@(posedge clk_i) disable iff (!rst_n_i) force_rst);
    COV_SERVICE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        wd_on && ce_i && sfr_we_i && sfr_sel_i == `CAWD_SEL_M5_COMPARE);
    COV_LOCK:    cover property (@(posedge clk_i) disable iff (!rst_n_i)
        st.wd == WD_ON ##1 st.wd == WD_LOCKED);

endmodule : cawd_top

// File: dv/cawd_top_tb_top.sv
`timescale 1ns/1ns
`include "cawd_defines.svh"

module cawd_top_tb_top
    import cawd_pkg::*;
;
    logic       clk_i;
    logic       rst_n_i;
    logic       ce_i;
    logic [2:0] sfr_sel_i;
    logic       sfr_we_i;
    logic [7:0] sfr_wdata_i;
    logic [7:0] sfr_rdata_o;
    logic       cpu_idle_i;
    logic       tmr_ovf_i;
    logic       ext_clk_i;
    logic       wd_enabled_o;
    logic       wd_rst_o;
    int         bad_count;
    int         n_checks;
    int         seed;
    int         cyc = 0;
    int         n_pulse = 0;
    int         p0;
    int         t0;
    int         n;
    int         off;
    int         tmo;
    int         m_mode;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;

    cawd_top DUT (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .sfr_sel_i    (sfr_sel_i),
        .sfr_we_i     (sfr_we_i),
        .sfr_wdata_i  (sfr_wdata_i),
        .sfr_rdata_o  (sfr_rdata_o),
        .cpu_idle_i   (cpu_idle_i),
        .tmr_ovf_i    (tmr_ovf_i),
        .ext_clk_i    (ext_clk_i),
        .wd_enabled_o (wd_enabled_o),
        .wd_rst_o     (wd_rst_o)
    );

    always #2 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wd_rst_o === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end

    task conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task wr(input logic [2:0] s, input logic [7:0] d);
        @(negedge clk_i);
        sfr_sel_i   = s;
        sfr_wdata_i = d;
        sfr_we_i    = 1'b1;
        @(negedge clk_i);
        sfr_we_i = 1'b0;
    endtask : wr

    task rd(input logic [2:0] s, output logic [7:0] d);
        @(negedge clk_i);
        sfr_sel_i = s;
        sfr_we_i  = 1'b0;
        @(negedge clk_i);
        d = sfr_rdata_o;
    endtask : rd

    // Counts cycles until the reset pulse, then checks it is one cycle wide
    task wait_rst(input int lim, output int cnt);
        cnt = 0;
        while (wd_rst_o !== 1'b1) begin
            if (cnt >= lim) begin
                bad_count++;
                $display("mismatch wd_rst_o expected 1 seen 0");
                conclude();
            end
            @(negedge clk_i);
            cnt++;
        end
        @(negedge clk_i);
        chk("wd_rst_o width", 8'h00, {7'h0, wd_rst_o});
    endtask : wait_rst

    // Stands in for the system reset that the pulse would cause
    task sysrst;
        @(negedge clk_i);
        rst_n_i = 1'b0;
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        m_mode  = 8'h40;
    endtask : sysrst

    task cfg(input logic [7:0] m_off, input logic [7:0] m_on, input logic [7:0] o);
        wr(`CAWD_SEL_MODE, 8'h00);
        chk("wd_enabled_o", 8'h00, {7'h0, wd_enabled_o});
        wr(`CAWD_SEL_MODE, m_off);
        wr(`CAWD_SEL_M5_OFFSET, o);
        wr(`CAWD_SEL_MODE, m_on);
        m_mode = m_on;
        rd(`CAWD_SEL_MODE, a);
        chk("mode", m_mode[7:0], a);
    endtask : cfg

    initial begin
        clk_i       = 1'b0;
        rst_n_i     = 1'b0;
        ce_i        = 1'b1;
        sfr_sel_i   = 3'h0;
        sfr_we_i    = 1'b0;
        sfr_wdata_i = 8'h00;
        cpu_idle_i  = 1'b0;
        tmr_ovf_i   = 1'b0;
        ext_clk_i   = 1'b0;
        bad_count   = 0;
        n_checks    = 0;
        seed        = 32'h21F5;
        m_mode      = 8'h40;
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        chk("wd_enabled_o", 8'h01, {7'h0, wd_enabled_o});
        rd(`CAWD_SEL_MODE, a);
        chk("mode", m_mode[7:0], a);
        rd(`CAWD_SEL_M5_OFFSET, a);
        chk("offset", 8'h00, a);
        rd(`CAWD_SEL_CTL, a);
        chk("run bit", 8'h00, {7'h0, a[`CAWD_CTL_CR]});
        wr(`CAWD_SEL_CNT_HI, 8'h80);
        rd(`CAWD_SEL_CNT_HI, a);
        chk("high byte", 8'h00, a);
        wr(`CAWD_SEL_CNT_LO, 8'hF0);
        rd(`CAWD_SEL_CNT_LO, a);
        chk("low byte small", 8'h01, {7'h0, a < 8'h08});
        wr(`CAWD_SEL_MODE, 8'hC8);
        rd(`CAWD_SEL_MODE, a);
        chk("mode frozen", m_mode[7:0], a);
        wr(`CAWD_SEL_M5_MODE, 8'h00);
        rd(`CAWD_SEL_M5_MODE, a);
        chk("m5 mode", `CAWD_M5_SWT, a);
        wr(`CAWD_SEL_CTL, 8'h00);
        rd(`CAWD_SEL_CNT_LO, a);
        repeat (24) @(negedge clk_i);
        rd(`CAWD_SEL_CNT_LO, b);
        chk("counter running", 8'h01, {7'h0, a != b});
        sysrst();
        wait_rst(3200, n);
        chk("default timeout", 8'h01, {7'h0, n >= 3066 && n <= 3100});
        sysrst();
        wr(`CAWD_SEL_CTL, 8'h20);
        wait_rst(3, n);
        chk("force latency", 8'h01, {7'h0, n <= 1});
        sysrst();
        wr(`CAWD_SEL_MODE, 8'h00);
        p0 = n_pulse;
        wr(`CAWD_SEL_CTL, 8'h20);
        repeat (4) @(negedge clk_i);
        chk("force when off", 8'h00, 8'(n_pulse - p0));
        cfg(8'h88, 8'hC8, 8'h02);
        cpu_idle_i = 1'b1;
        rd(`CAWD_SEL_CNT_LO, a);
        repeat (10) @(negedge clk_i);
        rd(`CAWD_SEL_CNT_LO, b);
        chk("idle hold", a, b);
        cpu_idle_i = 1'b0;
        // Clock enable low must freeze the counter
        rd(`CAWD_SEL_CNT_LO, a);
        ce_i = 1'b0;
        repeat (20) @(negedge clk_i);
        ce_i = 1'b1;
        rd(`CAWD_SEL_CNT_LO, b);
        chk("ce freeze", 8'h01, {7'h0, 8'(b - a) < 8'h08});
        for (int i = 0; i < 3; i++) begin
            off = $random(seed) & 3;
            cfg(8'h08, 8'h48, off[7:0]);
            rd(`CAWD_SEL_CNT_LO, a);
            rd(`CAWD_SEL_CNT_HI, b);
            wr(`CAWD_SEL_M5_COMPARE, 8'hA5);
            t0 = cyc;
            rd(`CAWD_SEL_M5_COMPARE, c);
            // High byte may step between the two reads
            chk("compare", 8'h01, {7'h0, c == b + off[7:0] || c == b + off[7:0] + 8'h01});
            tmo = 256 * off + 256 - a;
            wait_rst(1200, n);
            n = cyc - t0;
            chk("timeout", 8'h01, {7'h0, n >= tmo - 8 && n <= tmo + 8});
            sysrst();
        end
        cfg(8'h08, 8'h48, 8'h02);
        // Compare is still zero here; service before the first low byte wrap
        wr(`CAWD_SEL_M5_COMPARE, 8'h00);
        p0 = n_pulse;
        repeat (8) begin
            repeat (300) @(negedge clk_i);
            wr(`CAWD_SEL_M5_COMPARE, 8'h00);
        end
        chk("serviced", 8'h00, 8'(n_pulse - p0));
        wr(`CAWD_SEL_MODE, 8'h20);
        wr(`CAWD_SEL_MODE, 8'h00);
        chk("locked on", 8'h01, {7'h0, wd_enabled_o});
        sysrst();
        rd(`CAWD_SEL_MODE, a);
        chk("mode after reset", m_mode[7:0], a);
        conclude();
    end
endmodule : cawd_top_tb_top
